// *** core/dbo_map.svh ***
// register offsets, field positions and timing counts of the burst-order core
`ifndef DBO_MAP_SVH
`define DBO_MAP_SVH

`define DBO_REG_CTRL 8'h00
`define DBO_REG_FIRST 8'h04
`define DBO_REG_SECOND 8'h08
`define DBO_REG_STATUS 8'h0c
`define DBO_CTRL_DM_BIT 0
`define DBO_CTRL_CRC_BIT 1
`define DBO_CTRL_RESET 2'h0

`define DBO_MT_WIDTH 22
`define DBO_SEL_FIRST 3'h0
`define DBO_SEL_SECOND 3'h1
`define DBO_BL_LSB 0
`define DBO_BL_EIGHT 2'h0
`define DBO_BL_OTF 2'h1
`define DBO_BL_CHOP 2'h2
`define DBO_BT_BIT 3
`define DBO_TM_BIT 7
`define DBO_LOCK_RST_BIT 8
`define DBO_AL_LSB 3
`define DBO_AP_BIT 10
`define DBO_CHOP_PIN_BIT 12

`define DBO_LAST_SLOT 3'h7
`define DBO_CHOP_PULL_IN 3'h2
`define DBO_ROW_CLOSE_CLKS 8'h08

`endif

// *** core/dbo_pkg.sv ***
// types shared by the burst-order core
package dbo_pkg;
  typedef enum logic [1:0] {
    dbo_idle,
    dbo_rd_wait,
    dbo_rd_burst,
    dbo_wr_burst
  } dbo_state_type;
endpackage : dbo_pkg

// *** core/dbo_latency_decode.sv ***
// decodes latency, recovery and read-to-close clocks from the mode tables
`timescale 1ns/1ps
`include "dbo_map.svh"
module dbo_latency_decode (
  input wire logic [21:0] first_mode_table,
  input wire logic [21:0] second_mode_table,
  output logic [7:0] column_read_latency,
  output logic [7:0] total_read_delay,
  output logic [7:0] write_recovery,
  output logic [7:0] read_to_close_delay
);
  logic [7:0] posted_command_delay;

  always_comb begin
    case ({first_mode_table[12], first_mode_table[6:4],
           first_mode_table[2]})
      5'h00: column_read_latency = 8'h09;
      5'h01: column_read_latency = 8'h0a;
      5'h02: column_read_latency = 8'h0b;
      5'h03: column_read_latency = 8'h0c;
      5'h04: column_read_latency = 8'h0d;
      5'h05: column_read_latency = 8'h0e;
      5'h06: column_read_latency = 8'h0f;
      5'h07: column_read_latency = 8'h10;
      5'h08: column_read_latency = 8'h12;
      5'h09: column_read_latency = 8'h14;
      5'h0a: column_read_latency = 8'h16;
      5'h0b: column_read_latency = 8'h18;
      5'h0c: column_read_latency = 8'h17;
      5'h0d: column_read_latency = 8'h11;
      5'h0e: column_read_latency = 8'h13;
      5'h0f: column_read_latency = 8'h15;
      5'h10: column_read_latency = 8'h19;
      5'h11: column_read_latency = 8'h1a;
      5'h13: column_read_latency = 8'h1c;
      5'h14: column_read_latency = 8'h1d;
      5'h15: column_read_latency = 8'h1e;
      5'h16: column_read_latency = 8'h1f;
      // unlisted codes fall back to the longest latency, which is always safe
      default: column_read_latency = 8'h20;
    endcase
    case (second_mode_table[`DBO_AL_LSB +: 2])
      2'h1: posted_command_delay = column_read_latency - 8'h01;
      2'h2: posted_command_delay = column_read_latency - 8'h02;
      default: posted_command_delay = 8'h00;
    endcase
    total_read_delay = posted_command_delay + column_read_latency;
    case ({first_mode_table[13], first_mode_table[11:9]})
      4'h0: write_recovery = 8'h0a;
      4'h1: write_recovery = 8'h0c;
      4'h2: write_recovery = 8'h0e;
      4'h3: write_recovery = 8'h10;
      4'h4: write_recovery = 8'h12;
      4'h5: write_recovery = 8'h14;
      4'h6: write_recovery = 8'h18;
      4'h7: write_recovery = 8'h16;
      4'h8: write_recovery = 8'h1a;
      default: write_recovery = 8'h1c;
    endcase
    read_to_close_delay = {1'b0, write_recovery[7:1]};
  end
endmodule : dbo_latency_decode

// *** core/dbo_beat_order.sv ***
// column order of the eight read beats for a given start and ordering kind
`timescale 1ns/1ps
module dbo_beat_order (
  input wire logic [2:0] start_column,
  input wire logic burst_ordering_kind,
  output logic [23:0] beat_columns
);
  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_beat
      localparam logic [2:0] IDX = 3'(i);
      // sequential rotates inside each half; interleaved is a plain xor
      assign beat_columns[i*3 +: 3] = burst_ordering_kind ?
        (start_column ^ IDX) :
        {start_column[2] ^ IDX[2], start_column[1:0] + IDX[1:0]};
    end
  endgenerate
endmodule : dbo_beat_order

// *** core/dbo_core.sv ***
// device-side burst ordering, latency and mode-table core with AHB-Lite view
`timescale 1ns/1ps
`include "dbo_map.svh"

// Notes on behaviour
// - beat order follows burst length, ordering kind and start column bits.
// - fixed chop, fixed eight and on-the-fly length choice via chop pin.
// - sequential eight-beat read rotates within each half.
// - interleaved read beat i is start column xor i.
// - chopped read sends only the half chosen by top start bit.
// - last four slots of a chopped read leave data and strobe undriven.
// - chopped write picks half by top bit; full write stores in order.
// - fixed chop starts the internal write two clocks earlier.
// - on-the-fly chop writes keep the eight-beat internal write time.
// - first read data comes the total read delay in whole clocks later.
// - total read delay is posted delay plus column latency.
// - recovery plus row close time sets the auto-close write delay.
// - with mask and checksum on, a bad checksum blocks the write.
// - read-to-close plus row close time gates the next activate.
// - the lock-loop reset bit clears itself after the reset is issued.
// - mode-table write maps bank group, bank and address pins to bits.
// - burst length field codes eight, on-the-fly, chop, reserved.
// - bit three selects sequential or interleaved ordering.
module dbo_core #(
  parameter int DW = 8,
  parameter int NB = 8,
  parameter logic [7:0] ROW_CLOSE_CLKS = `DBO_ROW_CLOSE_CLKS
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic cmd_select,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [1:0] bank_group_pins,
  input wire logic [1:0] bank_select_pins,
  input wire logic [17:0] addr,
  input wire logic [DW-1:0] wdata,
  input wire logic wr_crc_error,
  output logic [DW-1:0] dq_out,
  output logic dq_oe,
  output logic dqs_oe,
  output logic store_ref_pulse,
  output logic write_blocked_pulse,
  output logic lock_reset_pulse,
  output logic act_allowed,
  output logic factory_test_active
);
  localparam int RW = $clog2(NB);

  typedef struct packed {
    dbo_pkg::dbo_state_type st;
    logic [21:0] mt0;
    logic [21:0] mt1;
    logic dm_en;
    logic crc_en;
    logic [7:0] cnt;
    logic [2:0] beat;
    logic [2:0] start;
    logic [RW-1:0] row;
    logic chop;
    logic autoclose;
    logic [7:0] close_cnt;
    logic [7:0] blocked;
    logic [8*DW-1:0] wbuf;
    logic [NB-1:0][8*DW-1:0] mem;
    logic [DW-1:0] dq_out;
    logic dq_oe;
    logic store_ref;
    logic blocked_pulse;
    logic lock_pulse;
    logic act_ok;
    logic ap_sel;
    logic ap_write;
    logic [7:0] ap_addr;
    logic [31:0] hrdata;
    logic ready;
  } dbo_core_state_type;

  localparam dbo_core_state_type RESET_STATE = '{
    st: dbo_pkg::dbo_idle, act_ok: 1'b1, ready: 1'b1, default: '0};

  dbo_core_state_type r;
  dbo_core_state_type n;
  logic [7:0] cl;
  logic [7:0] rl;
  logic [7:0] wr_clks;
  logic [7:0] rtp_clks;
  logic [23:0] rd_cols;
  logic is_mrs;
  logic is_read;
  logic is_write;
  logic [1:0] bl_field;
  logic cmd_chop;
  logic [2:0] commit_slot;
  logic [2:0] col;
  logic [2:0] src;
  logic [21:0] table_value;

  dbo_latency_decode u_decode (
    .first_mode_table(r.mt0),
    .second_mode_table(r.mt1),
    .column_read_latency(cl),
    .total_read_delay(rl),
    .write_recovery(wr_clks),
    .read_to_close_delay(rtp_clks)
  );

  dbo_beat_order u_order (
    .start_column(r.start),
    .burst_ordering_kind(r.mt0[`DBO_BT_BIT]),
    .beat_columns(rd_cols)
  );

  // command decode assumes strobes all low for a table write
  assign is_mrs = cmd_select && !ras_n && !cas_n && !we_n;
  assign is_read = cmd_select && ras_n && !cas_n && we_n;
  assign is_write = cmd_select && ras_n && !cas_n && !we_n;
  assign bl_field = r.mt0[`DBO_BL_LSB +: 2];
  // reserved length code behaves as fixed eight beats
  assign cmd_chop = (bl_field == `DBO_BL_CHOP) ||
    ((bl_field == `DBO_BL_OTF) && !addr[`DBO_CHOP_PIN_BIT]);
  // only the fixed chop setting pulls the internal write in
  assign commit_slot = (bl_field == `DBO_BL_CHOP) ?
    (`DBO_LAST_SLOT - `DBO_CHOP_PULL_IN) : `DBO_LAST_SLOT;
  // bit 21..18 from bank pins, 17 from A17, 16..14 unused
  assign table_value = {bank_group_pins, bank_select_pins, addr[17],
    3'h0, addr[13:0]};

  always_comb begin
    n = r;
    col = '0;
    src = '0;
    n.dq_oe = 1'b0;
    n.store_ref = 1'b0;
    n.blocked_pulse = 1'b0;
    n.lock_pulse = 1'b0;
    if (r.mt0[`DBO_LOCK_RST_BIT]) begin
      n.mt0[`DBO_LOCK_RST_BIT] = 1'b0;
    end
    if (r.close_cnt != 8'h00) begin
      n.close_cnt = r.close_cnt - 8'h01;
    end
    n.act_ok = (n.close_cnt == 8'h00);

    if (is_mrs) begin
      if ({bank_group_pins[0], bank_select_pins} == `DBO_SEL_FIRST) begin
        n.mt0 = table_value;
        n.lock_pulse = addr[`DBO_LOCK_RST_BIT];
      end else if ({bank_group_pins[0], bank_select_pins} ==
                   `DBO_SEL_SECOND) begin
        n.mt1 = table_value;
      end
    end

    case (r.st)
      dbo_pkg::dbo_idle: begin
        // a burst in flight makes later read or write commands be ignored
        if (is_read || is_write) begin
          n.start = addr[2:0];
          n.row = addr[3 +: RW];
          n.chop = cmd_chop;
          n.autoclose = addr[`DBO_AP_BIT];
          n.beat = 3'h0;
          n.cnt = rl;
          n.st = is_read ? dbo_pkg::dbo_rd_wait : dbo_pkg::dbo_wr_burst;
        end
      end
      dbo_pkg::dbo_rd_wait: begin
        if (r.cnt == 8'h01) begin
          n.dq_out = r.mem[r.row][rd_cols[2:0]*DW +: DW];
          n.dq_oe = 1'b1;
          n.beat = 3'h1;
          n.st = dbo_pkg::dbo_rd_burst;
        end else begin
          n.cnt = r.cnt - 8'h01;
        end
      end
      dbo_pkg::dbo_rd_burst: begin
        n.dq_out = r.mem[r.row][rd_cols[r.beat*3 +: 3]*DW +: DW];
        n.dq_oe = !(r.chop && r.beat[2]);
        n.beat = r.beat + 3'h1;
        if (r.beat == `DBO_LAST_SLOT) begin
          n.st = dbo_pkg::dbo_idle;
          if (r.autoclose) begin
            n.close_cnt = rtp_clks + ROW_CLOSE_CLKS;
            n.act_ok = 1'b0;
          end
        end
      end
      dbo_pkg::dbo_wr_burst: begin
        if (!r.chop || !r.beat[2]) begin
          n.wbuf[r.beat*DW +: DW] = wdata;
        end
        if (r.beat == commit_slot) begin
          n.store_ref = 1'b1;
          if (r.dm_en && r.crc_en && wr_crc_error) begin
            n.blocked_pulse = 1'b1;
            n.blocked = r.blocked + 8'h01;
          end else begin
            for (int c = 0; c < 8; c++) begin
              col = 3'(c);
              src = r.chop ? {1'b0, col[1:0]} : col;
              if (!r.chop || col[2] == r.start[2]) begin
                n.mem[r.row][c*DW +: DW] = n.wbuf[src*DW +: DW];
              end
            end
          end
          if (r.autoclose) begin
            n.close_cnt = wr_clks + ROW_CLOSE_CLKS;
            n.act_ok = 1'b0;
          end
        end
        n.beat = r.beat + 3'h1;
        if (r.beat == `DBO_LAST_SLOT) begin
          n.st = dbo_pkg::dbo_idle;
        end
      end
      default: n.st = dbo_pkg::dbo_idle;
    endcase

    // bus data phase: only the control register takes writes
    if (r.ap_sel && r.ap_write && r.ap_addr == `DBO_REG_CTRL) begin
      n.dm_en = hwdata[`DBO_CTRL_DM_BIT];
      n.crc_en = hwdata[`DBO_CTRL_CRC_BIT];
    end
    n.ap_sel = hsel && htrans[1] && hready;
    n.ap_write = hwrite;
    n.ap_addr = haddr[7:0];
    if (hsel && htrans[1] && hready && !hwrite) begin
      if (haddr[7:0] == `DBO_REG_CTRL) begin
        n.hrdata = {30'h0, r.crc_en, r.dm_en};
      end else if (haddr[7:0] == `DBO_REG_FIRST) begin
        n.hrdata = {10'h0, r.mt0};
      end else if (haddr[7:0] == `DBO_REG_SECOND) begin
        n.hrdata = {10'h0, r.mt1};
      end else if (haddr[7:0] == `DBO_REG_STATUS) begin
        n.hrdata = {16'h0, r.blocked, 4'h0, r.mt0[`DBO_TM_BIT],
          r.act_ok, r.st != dbo_pkg::dbo_idle, r.chop};
      end else begin
        n.hrdata = 32'h0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= RESET_STATE;
    end else begin
      r <= n;
    end
  end

  assign hrdata = r.hrdata;
  assign hreadyout = r.ready;
  assign hresp = r.blocked_pulse & ~r.blocked_pulse;
  assign dq_out = r.dq_out;
  assign dq_oe = r.dq_oe;
  assign dqs_oe = r.dq_oe;
  assign store_ref_pulse = r.store_ref;
  assign write_blocked_pulse = r.blocked_pulse;
  assign lock_reset_pulse = r.lock_pulse;
  assign act_allowed = r.act_ok;
  // the test setting is only reported, never acted upon
  assign factory_test_active = r.mt0[`DBO_TM_BIT];
endmodule : dbo_core

// *** core/dbo_core_end.sv ***
// spare file of the burst-order core; it holds no logic

// *** verif/dbo_monitor.sv ***
// port-level assertions of the burst-order core
`timescale 1ns/1ps
module dbo_monitor (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic cmd_select,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [1:0] bank_group_pins,
  input wire logic [1:0] bank_select_pins,
  input wire logic [17:0] addr,
  input wire logic dq_oe,
  input wire logic dqs_oe,
  input wire logic store_ref_pulse,
  input wire logic write_blocked_pulse,
  input wire logic lock_reset_pulse,
  input wire logic act_allowed
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic col_cmd;
  logic wr_cmd;
  logic tbl0_cmd;
  assign col_cmd = cmd_select && ras_n && !cas_n;
  assign wr_cmd = col_cmd && !we_n;
  assign tbl0_cmd = cmd_select && !ras_n && !cas_n && !we_n &&
    !bank_group_pins[0] && bank_select_pins == 2'h0;
  chk_strobe_pair: assert property (dq_oe == dqs_oe)
    else $error("strobe enable differs from data enable");
  chk_beats_min: assert property ($rose(dq_oe) |-> dq_oe[*4])
    else $error("read burst shorter than four beats");
  chk_beats_max: assert property ($rose(dq_oe) |-> ##8 !dq_oe)
    else $error("read burst drives past eight slots");
  // no read can answer sooner than the smallest latency of nine
  chk_cmd_quiet: assert property (col_cmd && !dq_oe |=> !dq_oe[*8])
    else $error("data driven too early after a command");
  chk_lock_pulse: assert property (tbl0_cmd && addr[8] |=>
    lock_reset_pulse ##1 !lock_reset_pulse)
    else $error("lock reset pulse missing or too long");
  chk_commit_time: assert property (wr_cmd && !dq_oe |->
    (##7 store_ref_pulse) or (##9 store_ref_pulse))
    else $error("write commit at wrong slot");
  chk_block_ref: assert property (write_blocked_pulse |-> store_ref_pulse)
    else $error("blocked write outside a commit");
  chk_close_hold: assert property ($fell(act_allowed) |->
    !act_allowed[*8])
    else $error("activate allowed before row close time");
endmodule : dbo_monitor

bind dbo_core dbo_monitor mon (.hclk, .hresetn, .cmd_select, .ras_n,
  .cas_n, .we_n, .bank_group_pins, .bank_select_pins, .addr, .dq_oe,
  .dqs_oe, .store_ref_pulse, .write_blocked_pulse, .lock_reset_pulse,
  .act_allowed);

// *** verif/dbo_ctrl_model.sv ***
// memory-controller model issuing commands and write bursts
`timescale 1ns/1ps
module dbo_ctrl_model #(
  parameter int LOCK_SETTLE = 16
) (
  input wire logic hclk,
  output logic cmd_select,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic [1:0] bank_group_pins,
  output logic [1:0] bank_select_pins,
  output logic [17:0] addr,
  output logic [7:0] wdata,
  output logic wr_crc_error
);
  initial begin
    cmd_select = 1'b0;
    {ras_n, cas_n, we_n} = 3'h7;
    {bank_group_pins, bank_select_pins} = 4'h0;
    addr = 18'h0;
    wdata = 8'h0;
    wr_crc_error = 1'b0;
  end
  task automatic issue(input logic [2:0] c, input logic [3:0] b,
    input logic [17:0] a);
    cmd_select <= 1'b1;
    {ras_n, cas_n, we_n} <= c;
    {bank_group_pins, bank_select_pins} <= b;
    addr <= a;
    @(posedge hclk);
    cmd_select <= 1'b0;
    {ras_n, cas_n, we_n} <= 3'h7;
    // deselected address pins flip so a stale value is never mistaken for a fresh one
    addr <= ~a;
  endtask : issue
  task automatic table_wr(input logic [3:0] b, input logic [17:0] a);
    issue(3'h0, b, a & 18'h3ff7f);
    @(posedge hclk);
    if (a[8]) repeat (LOCK_SETTLE) @(posedge hclk);
  endtask : table_wr
  task automatic burst(input logic [63:0] d, input logic err);
    for (int k = 0; k < 8; k++) begin
      wdata <= d[8*k +: 8];
      wr_crc_error <= err;
      @(posedge hclk);
    end
    wdata <= ~d[63:56];
    wr_crc_error <= 1'b0;
  endtask : burst
endmodule : dbo_ctrl_model

// *** verif/dbo_core_bench.sv ***
// self-checking bench of the burst-order core
`timescale 1ns/1ps
`include "dbo_map.svh"
module dbo_core_bench;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, cmd_select;
  logic ras_n, cas_n, we_n, wr_crc_error, dq_oe, dqs_oe, act_allowed;
  logic store_ref_pulse, write_blocked_pulse, lock_reset_pulse;
  logic factory_test_active;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0] htrans, bank_group_pins, bank_select_pins;
  logic [17:0] addr;
  logic [7:0] wdata, dq_out;
  logic [7:0] mem [8];
  logic [7:0] exq [$];
  logic bt;
  int err_count, checks;
  dbo_core dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .cmd_select, .ras_n, .cas_n, .we_n, .bank_group_pins, .bank_select_pins,
    .addr, .wdata, .wr_crc_error, .dq_out, .dq_oe, .dqs_oe, .store_ref_pulse,
    .write_blocked_pulse, .lock_reset_pulse, .act_allowed,
    .factory_test_active);
  dbo_ctrl_model m (.hclk, .cmd_select, .ras_n, .cas_n, .we_n,
    .bank_group_pins, .bank_select_pins, .addr, .wdata, .wr_crc_error);
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : cmp
  task automatic end_sim();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim
  function automatic logic [2:0] ord(input logic [2:0] s, input logic [2:0] i);
    return bt ? s ^ i : {s[2] ^ i[2], s[1:0] + i[1:0]};
  endfunction : ord
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    for (int k = 0; k < 2; k++) begin
      n = 0;
      do begin @(posedge hclk); n++; end
      while (hreadyout !== 1'b1 && n < 20);
      if (n == 20) begin
        err_count++;
        end_sim();
      end
      if (k == 0) begin
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
      end
    end
    r = hrdata;
    cmp(hresp, 32'h0);
  endtask : bus
  task automatic rd(input logic [17:0] a, input int nb, input int rl);
    int n;
    for (int i = 0; i < nb; i++) exq.push_back(mem[ord(a[2:0], 3'(i))]);
    m.issue(3'h5, 4'h0, a);
    n = 0;
    do begin @(negedge hclk); n++; end
    while (dq_oe !== 1'b1 && n < 40);
    cmp(n, rl + 1);
    if (n == 40) end_sim();
    repeat (9) @(posedge hclk);
  endtask : rd
  task automatic wr(input logic [17:0] a, input logic c, input int ct,
    input logic err);
    logic [63:0] d;
    int n;
    d = {$urandom, $urandom};
    m.issue(3'h4, 4'h0, a);
    fork
      m.burst(d, err);
      begin
        n = 0;
        do begin @(negedge hclk); n++; end
        while (store_ref_pulse !== 1'b1 && n < 20);
        cmp(n, ct);
        if (n == 20) end_sim();
        cmp(write_blocked_pulse, err);
      end
    join
    for (int k = 0; k < 8; k++)
      if (!err && (!c || k < 4))
        mem[(c ? {a[2], 2'h0} : 3'h0) + k] = d[8*k +: 8];
  endtask : wr
  task automatic act_cnt(input int e);
    int n;
    n = 0;
    repeat (60) begin
      @(negedge hclk);
      if (act_allowed !== 1'b1) n++;
    end
    cmp(n, e);
  endtask : act_cnt
  // a beat with nothing noted against it is compared with x and so fails
  always @(negedge hclk)
    if (dq_oe === 1'b1) cmp(dq_out, exq.size() ? exq.pop_front() : 'x);
  initial begin
    repeat (100000) @(posedge hclk);
    err_count++;
    end_sim();
  end
  initial begin
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    hresetn = 1'b0;
    bt = 1'b0;
    err_count = 0;
    checks = 0;
    void'($urandom(27611));
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b0, 8'h10, 32'h0);
    cmp(r, 32'h0);
    bus(1'b1, `DBO_REG_CTRL, 32'h3);
    bus(1'b0, `DBO_REG_CTRL, 32'h0);
    cmp(r, 32'h3);
    m.table_wr(4'h1, 18'h00001);
    m.table_wr(4'h0, 18'h00300);
    bus(1'b0, `DBO_REG_FIRST, 32'h0);
    cmp(r, 32'h200);
    bus(1'b0, `DBO_REG_SECOND, 32'h0);
    cmp(r, 32'h40001);
    wr(18'h5, 1'b0, 9, 1'b0);
    for (int t = 0; t < 2; t++) begin
      bt = t[0];
      m.table_wr(4'h0, {14'h20, t[0], 3'h0});
      for (int s = 0; s < 8; s++) rd(18'(s), 8, 9);
    end
    m.table_wr(4'h0, 18'h20a);
    wr(18'h6, 1'b1, 7, 1'b0);
    for (int s = 0; s < 8; s++) rd(18'(s), 4, 9);
    bt = 1'b0;
    m.table_wr(4'h0, 18'h201);
    wr(18'h1, 1'b1, 9, 1'b0);
    rd(18'h1003, 8, 9);
    rd(18'h0006, 4, 9);
    fork
      wr(18'h1400, 1'b0, 9, 1'b1);
      act_cnt(20);
    join
    fork
      rd(18'h1402, 8, 9);
      act_cnt(14);
    join
    m.table_wr(4'h0, 18'h205);
    m.table_wr(4'h1, 18'h00009);
    rd(18'h1007, 8, 19);
    cmp(exq.size(), 0);
    // one blocked write so far, auto-close idle, last read was eight beats
    bus(1'b0, `DBO_REG_STATUS, 32'h0);
    cmp(r, 32'h0104);
    cmp(factory_test_active, 32'h0);
    end_sim();
  end
endmodule : dbo_core_bench
